// >>> rtl/nv_byte_store_controller.sv
// Operation
// - Nine-bit linear byte index addressing
// - Unused index and control bits read zero
// - Value register feeds writes, holds reads
// - Action select picks erase/program timing
// - Action select frozen while strobe set
// - Reset clears action select unless busy
// - Ready interrupt while enabled and idle
// - No ready interrupt during any programming
// - Arm bit self-clears after four cycles
// - Strobe starts only while armed
// - Write start held off during flash self-programming
// - Hardware clears strobe when done
// - Write start halts core two cycles
// - Read fetches at once, halts four
// - Busy blocks reads and index changes
// - Timing counted in RC oscillator cycles
// - Data-space address is I/O plus 0x20
// - Reset lets programming run to end
`default_nettype none
module nv_byte_store_controller #(
  parameter int         DEPTH        = 512,      // Bytes of storage
  parameter logic [14:0] ATOMIC_TICKS = 15'd26368, // Erase plus program
  parameter logic [14:0] SPLIT_TICKS  = 15'd13960  // Erase or program
) (
  input  wire logic                  mclk,          // Core clock
  input  wire logic                  rst_n,         // Power-on reset
  input  wire logic                  sys_reset,     // System reset pin
  input  wire logic                  rc_osc,        // Calibrated RC clock
  input  wire nv_store_pkg::io_req_t req,           // Core I/O request
  input  wire logic                  global_ie,     // Core flags I bit
  input  wire logic                  flash_selfprog_flag, // Flash busy
  output logic [7:0]                 rdata,         // Load result
  output logic                       stall,         // Core halt
  output logic                       ready_irq      // Ready interrupt
);
  ////////////////////////////////////////////////////////////////
  // State carrier
  typedef struct packed {
    logic [8:0]         byte_index;   // Current index
    logic [7:0]         byte_value;   // Value register
    logic [1:0]         mode;         // Action select
    logic               irq_en;       // Ready interrupt enable
    logic [2:0]         arm_cnt;      // Arm lifetime left
    nv_store_pkg::eng_t eng;          // Engine state
    logic [14:0]        ticks;        // RC cycles left
    logic [8:0]         op_index;     // Latched index
    logic [7:0]         op_value;     // Latched value
    logic [1:0]         op_mode;      // Latched action
    logic [2:0]         stall_cnt;    // Halt cycles left
    logic               stall;        // Halt output
    logic               irq;          // Interrupt output
    logic [7:0]         rdata;        // Load result
    logic [1:0]         rst_sync;     // System reset sync
    logic [2:0]         osc_sync;     // RC sync and history
  } state_t;

  state_t     cur;      // Registered state
  state_t     next_cur; // Next state
  logic [7:0] mem [DEPTH]; // Storage array
  logic       mem_we;   // Array write
  logic [7:0] mem_wd;   // Array write data

  ////////////////////////////////////////////////////////////////
  // Helpers
  // Data-space hit on an I/O register
  function automatic logic ds_hit(input logic [7:0] a, input logic [7:0] io);
    ds_hit = (a == 8'(io + nv_store_pkg::DS_OFFSET));
  endfunction

  // Control register image
  function automatic logic [7:0] ctl_image(input state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[nv_store_pkg::CTL_MODE_HI] = s.mode[1];
    v[nv_store_pkg::CTL_MODE_LO] = s.mode[0];
    v[nv_store_pkg::CTL_IRQ_EN]  = s.irq_en;
    v[nv_store_pkg::CTL_ARM]     = (s.arm_cnt != 3'h0);
    v[nv_store_pkg::CTL_WRITE]   = (s.eng != nv_store_pkg::ENG_IDLE);
    ctl_image = v;
  endfunction

  // Index limited to the fitted size
  function automatic logic [8:0] clip(input logic [8:0] i);
    clip = 9'(i & 9'(DEPTH - 1));
  endfunction

  ////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    logic       busy;      // Programming in progress
    logic       ctl_wr;    // Control register written
    logic [7:0] ctl_val;   // Value written to control
    logic       osc_edge;  // One RC cycle seen
    logic       sys_rst;   // Synchronised system reset
    busy     = 1'b0;
    ctl_wr   = 1'b0;
    ctl_val  = 8'h00;
    osc_edge = 1'b0;
    sys_rst  = 1'b0;
    next_cur = cur;
    mem_we   = 1'b0;
    mem_wd   = nv_store_pkg::ERASED_VALUE;
    // Synchronisers
    next_cur.rst_sync = {cur.rst_sync[0], sys_reset};
    next_cur.osc_sync = {cur.osc_sync[1:0], rc_osc};
    sys_rst  = cur.rst_sync[1];
    osc_edge = cur.osc_sync[1] & ~cur.osc_sync[2];
    busy     = (cur.eng != nv_store_pkg::ENG_IDLE);
    // Arm lifetime
    // four-cycle timeout
    if (cur.arm_cnt != 3'h0)
    begin
      next_cur.arm_cnt = cur.arm_cnt - 3'h1;
    end
    // Core halt countdown
    if (cur.stall_cnt != 3'h0)
    begin
      next_cur.stall_cnt = cur.stall_cnt - 3'h1;
    end
    // Control write by store or bit op
    if (req.wr && ds_hit(req.addr, nv_store_pkg::IO_CONTROL))
    begin
      ctl_wr  = 1'b1;
      ctl_val = req.wdata;
    end
    else if ((req.bit_set || req.bit_clr) &&
             (8'(req.bit_addr) == nv_store_pkg::IO_CONTROL))
    begin
      ctl_wr  = 1'b1;
      ctl_val = ctl_image(cur);
      ctl_val[nv_store_pkg::CTL_ARM] = 1'b0;
      ctl_val[req.bit_num] = req.bit_set;
    end
    // Index and value stores
    if (req.wr && !busy)
    begin
      if (ds_hit(req.addr, nv_store_pkg::IO_INDEX_LOW))
      begin
        next_cur.byte_index = clip({cur.byte_index[8], req.wdata});
      end
      else if (ds_hit(req.addr, nv_store_pkg::IO_INDEX_HIGH))
      begin
        next_cur.byte_index = clip({req.wdata[0], cur.byte_index[7:0]});
      end
    end
    if (req.wr && ds_hit(req.addr, nv_store_pkg::IO_VALUE))
    begin
      next_cur.byte_value = req.wdata;
    end
    // Control fields
    if (ctl_wr)
    begin
      next_cur.irq_en = ctl_val[nv_store_pkg::CTL_IRQ_EN];
      if (!busy)
      begin
        next_cur.mode = {ctl_val[nv_store_pkg::CTL_MODE_HI],
                         ctl_val[nv_store_pkg::CTL_MODE_LO]};
      end
      // Arm set restarts lifetime
      if (ctl_val[nv_store_pkg::CTL_ARM])
      begin
        next_cur.arm_cnt = nv_store_pkg::ARM_CYCLES;
      end
      // Write strobe
      // start needs live arm
      if (ctl_val[nv_store_pkg::CTL_WRITE] && !busy && cur.arm_cnt != 3'h0)
      begin
        next_cur.op_index = cur.byte_index;
        next_cur.op_value = cur.byte_value;
        next_cur.op_mode  = cur.mode;
        next_cur.arm_cnt  = 3'h0;
        next_cur.stall_cnt = nv_store_pkg::WRITE_STALL;
        next_cur.ticks = (cur.mode == nv_store_pkg::ACT_ERASE_PROG) ?
                         ATOMIC_TICKS : SPLIT_TICKS;
        if (cur.mode == nv_store_pkg::ACT_RESERVED)
        begin
          next_cur.eng = nv_store_pkg::ENG_IDLE;
        end
        else
        begin
          next_cur.eng = nv_store_pkg::ENG_HOLD;
        end
      end
      // Read strobe
      // immediate fetch, four-cycle halt
      else if (ctl_val[nv_store_pkg::CTL_READ] && !busy)
      begin
        next_cur.byte_value = mem[cur.byte_index];
        next_cur.stall_cnt  = nv_store_pkg::READ_STALL;
      end
    end
    // Programming engine
    unique case (cur.eng)
      nv_store_pkg::ENG_IDLE:
      begin
        next_cur.ticks = next_cur.ticks;
      end
      nv_store_pkg::ENG_HOLD:
      begin
        if (!flash_selfprog_flag)
        begin
          next_cur.eng = nv_store_pkg::ENG_PROG;
        end
      end
      nv_store_pkg::ENG_PROG:
      begin
        if (osc_edge)
        begin
          next_cur.ticks = cur.ticks - 15'h1;
        end
        if (osc_edge && cur.ticks == 15'h1)
        begin
          next_cur.eng = nv_store_pkg::ENG_IDLE;
          mem_we = 1'b1;
          unique case (cur.op_mode)
            nv_store_pkg::ACT_ERASE:
            begin
              mem_wd = nv_store_pkg::ERASED_VALUE;
            end
            nv_store_pkg::ACT_PROG:
            begin
              mem_wd = mem[cur.op_index] & cur.op_value;
            end
            default:
            begin
              mem_wd = cur.op_value;
            end
          endcase
        end
      end
      default:
      begin
        next_cur.eng = nv_store_pkg::ENG_IDLE;
      end
    endcase
    // Load data
    next_cur.rdata = 8'h00;
    if (req.rd)
    begin
      if (ds_hit(req.addr, nv_store_pkg::IO_INDEX_LOW))
      begin
        next_cur.rdata = cur.byte_index[7:0];
      end
      else if (ds_hit(req.addr, nv_store_pkg::IO_INDEX_HIGH))
      begin
        next_cur.rdata = {7'h00, cur.byte_index[8]};
      end
      else if (ds_hit(req.addr, nv_store_pkg::IO_VALUE))
      begin
        next_cur.rdata = cur.byte_value;
      end
      else if (ds_hit(req.addr, nv_store_pkg::IO_CONTROL))
      begin
        next_cur.rdata = ctl_image(cur);
      end
    end
    // System reset of the register side
    if (sys_rst)
    begin
      next_cur.byte_index = nv_store_pkg::INDEX_RESET;
      next_cur.byte_value = nv_store_pkg::VALUE_RESET;
      next_cur.irq_en     = 1'b0;
      next_cur.arm_cnt    = 3'h0;
      next_cur.stall_cnt  = 3'h0;
      next_cur.rdata      = 8'h00;
      if (!busy)
      begin
        next_cur.mode = nv_store_pkg::MODE_RESET;
        next_cur.eng  = nv_store_pkg::ENG_IDLE;
      end
    end
    // Halt and interrupt outputs
    next_cur.stall = (next_cur.stall_cnt != 3'h0);
    next_cur.irq = next_cur.irq_en && global_ie && !flash_selfprog_flag &&
                   (next_cur.eng == nv_store_pkg::ENG_IDLE);
  end

  ////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur            <= '0;
      cur.eng        <= nv_store_pkg::ENG_IDLE;
      cur.mode       <= nv_store_pkg::MODE_RESET;
      cur.byte_index <= nv_store_pkg::INDEX_RESET;
      cur.byte_value <= nv_store_pkg::VALUE_RESET;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Storage array, no reset
  always_ff @(posedge mclk)
  begin
    if (mem_we)
    begin
      mem[cur.op_index] <= mem_wd;
    end
  end

  // Outputs from flops
  assign rdata     = cur.rdata;
  assign stall     = cur.stall;
  assign ready_irq = cur.irq;
endmodule
`default_nettype wire

// >>> rtl/nv_store_pkg.sv
`default_nettype none
package nv_store_pkg;
  ////////////////////////////////////////////////////////////////
  // I/O addresses and data-space distance
  localparam logic [7:0] IO_CONTROL    = 8'h1f; // Access control
  localparam logic [7:0] IO_VALUE      = 8'h20; // Byte value
  localparam logic [7:0] IO_INDEX_LOW  = 8'h21; // Index bits 7..0
  localparam logic [7:0] IO_INDEX_HIGH = 8'h22; // Index bit 8
  localparam logic [7:0] DS_OFFSET     = 8'h20; // Data-space shift
  localparam logic [7:0] BIT_IO_LAST   = 8'h1f; // Last bit-op address
  ////////////////////////////////////////////////////////////////
  // Control register field positions
  localparam int CTL_READ    = 0; // Read strobe
  localparam int CTL_WRITE   = 1; // Write strobe
  localparam int CTL_ARM     = 2; // Arm bit
  localparam int CTL_IRQ_EN  = 3; // Ready interrupt enable
  localparam int CTL_MODE_LO = 4; // Action select low
  localparam int CTL_MODE_HI = 5; // Action select high
  ////////////////////////////////////////////////////////////////
  // Reset values, counts and fill value
  localparam logic [1:0] MODE_RESET   = 2'h0; // Action select reset
  localparam logic [8:0] INDEX_RESET  = 9'h000; // Index reset
  localparam logic [7:0] VALUE_RESET  = 8'h00; // Byte value reset
  localparam logic [2:0] ARM_CYCLES   = 3'h4; // Arm lifetime
  localparam logic [2:0] WRITE_STALL  = 3'h2; // Core halt on write
  localparam logic [2:0] READ_STALL   = 3'h4; // Core halt on read
  localparam logic [7:0] ERASED_VALUE = 8'hff; // Erased byte
  localparam real ATOMIC_MS = 3.4; // Erase plus program time
  localparam real SPLIT_MS  = 1.8; // Erase or program time
  ////////////////////////////////////////////////////////////////
  // Action select codes
  typedef enum logic [1:0] {
    ACT_ERASE_PROG,
    ACT_ERASE,
    ACT_PROG,
    ACT_RESERVED
  } action_t;
  // Programming engine states
  typedef enum logic [1:0] {
    ENG_IDLE,
    ENG_HOLD,
    ENG_PROG
  } eng_t;
  // Core I/O request carrier
  typedef struct packed {
    logic       wr;       // Store to data space
    logic       rd;       // Load from data space
    logic [7:0] addr;     // Data-space address
    logic [7:0] wdata;    // Store data
    logic       bit_set;  // Single bit set
    logic       bit_clr;  // Single bit clear
    logic [4:0] bit_addr; // I/O address of bit op
    logic [2:0] bit_num;  // Bit number
  } io_req_t;
endpackage
`default_nettype wire

// >>> test/nv_store_props.sv
`default_nettype none
module nv_store_props (
  input wire logic                  mclk,                // Core clock
  input wire logic                  rst_n,               // Power-on reset
  input wire nv_store_pkg::io_req_t req,                 // Core request
  input wire logic                  global_ie,           // Core I flag
  input wire logic                  flash_selfprog_flag, // Flash busy
  input wire logic [7:0]            rdata,               // Load result
  input wire logic                  stall,               // Core halt
  input wire logic                  ready_irq            // Ready interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  // Data-space addresses of control and index high
  localparam logic [7:0] CTL_A = nv_store_pkg::IO_CONTROL + nv_store_pkg::DS_OFFSET;
  localparam logic [7:0] IDH_A = nv_store_pkg::IO_INDEX_HIGH + nv_store_pkg::DS_OFFSET;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////
  // Halt lasts two or four cycles
  a_stall_shape: assert property ($rose(stall) |=> stall ##1
    ((!stall) or (stall[*2] ##1 !stall)))
    else $error("stall length wrong");
  a_read_stall: assert property (ready_irq && req.wr && req.addr == CTL_A
    && req.wdata[1:0] == 2'b01 |=> stall[*4] ##1 !stall)
    else $error("read halt not four cycles");
  // Core leaves one idle cycle between stores, so arm and strobe are two apart
  a_write_start: assert property ((req.wr && req.addr == CTL_A && req.wdata[2]) ##2
    (ready_irq && req.wr && req.addr == CTL_A && req.wdata[2:1] == 2'b01
    && req.wdata[5:4] != 2'b11) |=> stall[*2] ##1 (!stall && !ready_irq))
    else $error("armed strobe did not start");
  // Interrupt gating
  a_irq_ie_gate: assert property (!global_ie |=> !ready_irq)
    else $error("interrupt without global enable");
  a_irq_flash: assert property (flash_selfprog_flag |=> !ready_irq)
    else $error("interrupt during flash programming");
  // Read-back of reserved bits and unmapped places
  a_unmapped: assert property (req.rd && (req.addr < CTL_A || req.addr > IDH_A)
    |=> rdata == 8'h00)
    else $error("unmapped load not zero");
  a_ctl_reserved: assert property (req.rd && req.addr == CTL_A |=> rdata[7:6] == 2'b00)
    else $error("control top bits not zero");
  a_idx_reserved: assert property (req.rd && req.addr == IDH_A |=> rdata[7:1] == 7'h00)
    else $error("index high upper bits not zero");
endmodule
bind nv_byte_store_controller nv_store_props i_nv_store_props (
  .mclk(mclk), .rst_n(rst_n), .req(req), .global_ie(global_ie),
  .flash_selfprog_flag(flash_selfprog_flag), .rdata(rdata), .stall(stall),
  .ready_irq(ready_irq));
`default_nettype wire

// >>> test/nv_core_model.sv
`default_nettype none
module nv_core_model (
  input  wire logic                 mclk,  // Core clock
  input  wire logic                 stall, // Core halt
  input  wire logic [7:0]           rdata, // Load result
  output var nv_store_pkg::io_req_t req    // Core request
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  //////////////////////////////////////////////////////////////
  // One-cycle access once halt is over; kind 0 load, 1 store, 2 set, 4 clear
  task automatic access(input logic [2:0] kind, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(negedge mclk);
    while (stall) @(negedge mclk);
    req.wr       = kind[0];
    req.rd       = (kind == 3'h0);
    req.bit_set  = kind[1];
    req.bit_clr  = kind[2];
    req.addr     = a;
    req.wdata    = d;
    req.bit_addr = a[4:0];
    req.bit_num  = d[2:0];
    @(negedge mclk);
    // Released lines show the inverse, not the old value
    req = {2'b00, ~a, ~d, 2'b00, ~a[4:0], ~d[2:0]};
    q = rdata;
  endtask
  // Load index and value, arm, then strobe two cycles later
  task automatic prog(input logic [8:0] idx, input logic [7:0] v, input logic [2:0] ctl);
    logic [7:0] q;
    access(3'h1, 8'h42, {7'h00, idx[8]}, q);
    access(3'h1, 8'h41, idx[7:0], q);
    access(3'h1, 8'h40, v, q);
    access(3'h1, 8'h3f, {2'b00, ctl, 3'b100}, q);
    access(3'h1, 8'h3f, {2'b00, ctl, 3'b010}, q);
  endtask
endmodule
`default_nettype wire

// >>> test/nv_byte_store_controller_tb_top.sv
`default_nettype none
module nv_byte_store_controller_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  mclk, rst_n, sys_reset, rc_osc, global_ie, flash_selfprog_flag;
  logic                  stall, ready_irq; // Design outputs
  logic [7:0]            rdata, q;         // Load result, scratch
  nv_store_pkg::io_req_t req;              // Core request
  int                    err_total, check_count;
  // Cases: action, index, value, expected byte
  typedef struct packed {logic [1:0] m; logic [8:0] idx; logic [7:0] v, e;} row_t;
  row_t rows [5] = '{'{2'h0, 9'h1a5, 8'h3c, 8'h3c}, '{2'h2, 9'h1a5, 8'hf0, 8'h30},
    '{2'h1, 9'h1a5, 8'h00, 8'hff}, '{2'h3, 9'h1a5, 8'h12, 8'hff}, '{2'h0, 9'h0a5, 8'h81, 8'h81}};
  nv_byte_store_controller #(.DEPTH(512), .ATOMIC_TICKS(15'd20), .SPLIT_TICKS(15'd10))
    i_nv_byte_store_controller (.mclk(mclk), .rst_n(rst_n), .sys_reset(sys_reset),
    .rc_osc(rc_osc), .req(req), .global_ie(global_ie), .flash_selfprog_flag(flash_selfprog_flag),
    .rdata(rdata), .stall(stall), .ready_irq(ready_irq));
  nv_core_model i_nv_core_model (.mclk(mclk), .stall(stall), .rdata(rdata), .req(req));
  //////////////////////////////////////////////////////////////
  // Clocks: core 50 ns, slow oscillator 400 ns
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial
  begin
    rc_osc = 1'b0;
    forever #200 rc_osc = ~rc_osc;
  end
  // Compare and count
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_nv_core_model.access(3'h1, a, d, q);
  endtask
  // Poll the strobe until it reads zero, bounded
  task automatic wait_idle();
    int n;
    n = 0;
    q = 8'h02;
    while (q[1] && n < 400)
    begin
      i_nv_core_model.access(3'h0, 8'h3f, 8'h00, q);
      n++;
    end
    chk("strobe_done", 8'h00, {7'h00, q[1]});
  endtask
  // Fetch one byte through the read strobe
  task automatic fetch(input logic [8:0] idx);
    wr(8'h42, {7'h00, idx[8]});
    wr(8'h41, idx[7:0]);
    wr(8'h3f, 8'h09);
    i_nv_core_model.access(3'h0, 8'h40, 8'h00, q);
  endtask
  task automatic rd_ctl(input logic [7:0] e);
    i_nv_core_model.access(3'h0, 8'h3f, 8'h00, q);
    chk("control", e, q);
  endtask
  task automatic pulse_sys_reset();
    sys_reset = 1'b1;
    repeat (2) @(negedge mclk);
    sys_reset = 1'b0;
    repeat (4) @(negedge mclk);
  endtask
  task automatic end_sim();
    if (err_total == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #1000000;
    err_total++;
    end_sim();
  end
  //////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {rst_n, sys_reset, global_ie, flash_selfprog_flag, err_total, check_count} = '0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    rd_ctl(8'h00);
    foreach (rows[i])
    begin
      wait_idle();
      i_nv_core_model.prog(rows[i].idx, rows[i].v, {rows[i].m, 1'b0});
      wait_idle();
      fetch(rows[i].idx);
      chk("row_value", rows[i].e, q);
    end
    fetch(9'h1a5);
    chk("upper_index", 8'hff, q);
    wr(8'h42, 8'hff);
    i_nv_core_model.access(3'h0, 8'h42, 8'h00, q);
    chk("index_high", 8'h01, q);
    i_nv_core_model.access(3'h0, 8'h43, 8'h00, q);
    chk("unmapped", 8'h00, q);
    wr(8'h3f, 8'h04);
    rd_ctl(8'h04);
    repeat (4) @(negedge mclk);
    rd_ctl(8'h00);
    wr(8'h3f, 8'h02);
    rd_ctl(8'h00);
    i_nv_core_model.access(3'h2, 8'h1f, 8'h03, q);
    rd_ctl(8'h08);
    global_ie = 1'b1;
    repeat (3) @(negedge mclk);
    chk("irq_idle", 8'h01, {7'h00, ready_irq});
    fetch(9'h0a5);
    chk("refetch", 8'h81, q);
    wr(8'h3f, 8'h08);
    i_nv_core_model.prog(9'h0a5, 8'h0f, 3'h5);
    chk("write_halt", 8'h01, {7'h00, stall});
    wr(8'h41, 8'h00);
    wr(8'h3f, 8'h19);
    rd_ctl(8'h2a);
    i_nv_core_model.access(3'h0, 8'h41, 8'h00, q);
    chk("index_busy", 8'ha5, q);
    chk("irq_busy", 8'h00, {7'h00, ready_irq});
    pulse_sys_reset();
    rd_ctl(8'h22);
    wait_idle();
    fetch(9'h0a5);
    chk("kept_write", 8'h01, q);
    wr(8'h3f, 8'h30);
    pulse_sys_reset();
    rd_ctl(8'h00);
    i_nv_core_model.access(3'h2, 8'h1f, 8'h03, q);
    flash_selfprog_flag = 1'b1;
    repeat (2) @(negedge mclk);
    chk("irq_flash", 8'h00, {7'h00, ready_irq});
    i_nv_core_model.prog(9'h010, 8'h5a, 3'h1);
    repeat (300) @(negedge mclk);
    rd_ctl(8'h0a);
    flash_selfprog_flag = 1'b0;
    wait_idle();
    fetch(9'h010);
    chk("late_write", 8'h5a, q);
    i_nv_core_model.access(3'h4, 8'h1f, 8'h03, q);
    rd_ctl(8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
